//--- include/uart_status_defines.svh
// What this block does
// - Error clear write clears PE, FRAMING_ERROR_FLAG, OVERRUN_ERROR_FLAG
// - Parity mismatch sets sticky parity error
// - Framing error sets sticky flag
// - Overrun sets sticky flag
// - Receive irq: enable and full or error
// - Errors invalidate data, drop FIFO enable
// - No FIFO: load sets, read clears full
// - FIFO: count reached sets, empty clears
// - FIFO idle over 8 baud sets full
// - Tx write clears empty, shift load sets
// - Tx irq: empty and enable
// - Soft clear forces empty and idle high
// - Tx write clears idle, drained sets idle
// - Idle irq: idle flag and enable
// - Flow enable bit switches flow control
// - Stop length from extend and base bits
// - Receive checks first stop bit only
// - Polarity bit inverts line both directions
// - Parity only in normal mode
// - Parity sense: zero even, one odd
// - Length code selects 8,5,6,7,9 bits
// - Mode code 000 normal, 001 multiproc
`ifndef UART_STATUS_DEFINES_SVH
`define UART_STATUS_DEFINES_SVH
`define ADDR_STATUS      4'h0
`define ADDR_FRAME       4'h4
`define ADDR_CONTROL     4'h8
`define ADDR_MODE        4'hC
`define ST_CLEAR_BIT     7
`define ST_PE_BIT        5
`define ST_FRE_BIT       4
`define ST_ORE_BIT       3
`define ST_FULL_BIT      2
`define ST_EMPTY_BIT     1
`define ST_IDLE_BIT      0
`define CT_SOFTCLR_BIT   7
`define CT_RIE_BIT       4
`define CT_TIE_BIT       3
`define CT_TX_IDLE_INTERRUPT_ENABLE_BIT      2
`define CT_FIDLE_BIT     1
`define CT_BASE_BIT      0
`define FR_FLOW_BIT      7
`define FR_EXT_BIT       6
`define FR_INV_BIT       5
`define FR_PEN_BIT       4
`define FR_ODD_BIT       3
`define MODE_NORMAL      3'h0
`define MODE_MULTI       3'h1
`define IDLE_BAUD_COUNT  4'h8
`define FRAME_RESET      8'h00
`endif

//--- include/uart_status_pkg.sv
package uart_status_pkg;
  typedef enum logic [1:0] {
    ADDR_PH = 2'b01,
    DATA_PH = 2'b10
  } bus_state_t;
  typedef struct packed {
    bus_state_t  bus;
    logic        wr;
    logic [3:0]  addr;
    logic        pe;
    logic        framing_error_flag;
    logic        overrun_error_flag;
    logic        full;
    logic        empty;
    logic        idle;
    logic [7:0]  frame;
    logic [4:0]  ctrl;
    logic [2:0]  mode;
    logic        fifo_en;
    logic [3:0]  idle_cnt;
  } state_t;
endpackage : uart_status_pkg

//--- core/uart_status_and_frame_config.sv
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "uart_status_defines.svh"
module uart_status_and_frame_config (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Receiver events
  input  wire logic        i_rx_word_valid,
  input  wire logic        i_rx_parity_bad,
  input  wire logic        i_rx_stop_bad,
  input  wire logic        i_rx_overrun,
  input  wire logic        i_rx_data_read,
  input  wire logic        i_fifo_enable_req,
  input  wire logic        i_fifo_count_reached,
  input  wire logic        i_fifo_empty,
  input  wire logic        i_rx_line_idle,
  input  wire logic        i_baud_tick,
  // Transmitter events
  input  wire logic        i_tx_data_write,
  input  wire logic        i_tx_shift_load,
  input  wire logic        i_tx_shifting,
  // Serial line
  input  wire logic        i_line_in,
  input  wire logic        i_tx_bit,
  output logic             o_line_out,
  output logic             o_rx_bit,
  // Frame outputs
  output logic             o_rx_irq,
  output logic             o_tx_irq,
  output logic             o_flow_control_on,
  output logic      [2:0]  o_stop_bits,
  output logic      [3:0]  o_data_bits,
  output logic             o_parity_on,
  output logic             o_parity_odd,
  output logic             o_check_first_stop_only,
  output logic             o_fifo_store_ok,
  output logic             o_rx_data_valid,
  output logic             o_soft_clear
);
  import uart_status_pkg::*;

  state_t s;
  state_t next_s;
  logic   wr_en;
  logic   rd_en;
  logic   any_err;
  logic   err_clr;
  logic   soft_clr;
  logic   normal;

  // ************************************************************
  // Bus decode
  // ************************************************************
  assign wr_en = (s.bus == DATA_PH) && s.wr;
  assign rd_en = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  assign err_clr = wr_en && (s.addr == `ADDR_STATUS) &&
                   i_hwdata[`ST_CLEAR_BIT];
  assign soft_clr = wr_en && (s.addr == `ADDR_CONTROL) &&
                    i_hwdata[`CT_SOFTCLR_BIT];
  assign normal = (s.mode == `MODE_NORMAL);
  assign any_err = s.pe || s.framing_error_flag || s.overrun_error_flag;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_s = s;
    next_s.bus = ADDR_PH;
    next_s.wr = 1'b0;
    if (i_hsel && i_hready && i_htrans[1]) begin
      next_s.bus = DATA_PH;
      next_s.wr = i_hwrite;
      next_s.addr = i_haddr[3:0];
    end
    if (wr_en && s.addr == `ADDR_FRAME) begin
      next_s.frame = i_hwdata[7:0];
    end
    if (wr_en && s.addr == `ADDR_CONTROL) begin
      next_s.ctrl = i_hwdata[4:0];
    end
    if (wr_en && s.addr == `ADDR_MODE) begin
      next_s.mode = i_hwdata[2:0];
    end
    if (err_clr) begin
      next_s.pe = 1'b0;
      next_s.framing_error_flag = 1'b0;
      next_s.overrun_error_flag = 1'b0;
    end
    if (i_rx_word_valid && o_parity_on && i_rx_parity_bad) begin
      next_s.pe = 1'b1;
    end
    if (i_rx_word_valid && i_rx_stop_bad) begin
      next_s.framing_error_flag = 1'b1;
    end
    if (i_rx_overrun) begin
      next_s.overrun_error_flag = 1'b1;
    end
    if (i_fifo_enable_req) begin
      next_s.fifo_en = 1'b1;
    end
    if (any_err) begin
      next_s.fifo_en = 1'b0;
    end
    if (!s.fifo_en) begin
      if (i_rx_data_read) begin
        next_s.full = 1'b0;
      end
      if (i_rx_word_valid) begin
        next_s.full = 1'b1;
      end
      next_s.idle_cnt = 4'h0;
    end else begin
      if (i_fifo_empty) begin
        next_s.full = 1'b0;
      end
      if (i_fifo_count_reached) begin
        next_s.full = 1'b1;
      end
      if (!s.ctrl[`CT_FIDLE_BIT] || i_fifo_empty ||
          i_fifo_count_reached || !i_rx_line_idle ||
          i_rx_data_read) begin
        next_s.idle_cnt = 4'h0;
      end else if (i_baud_tick) begin
        if (s.idle_cnt == `IDLE_BAUD_COUNT) begin
          next_s.full = 1'b1;
        end else begin
          next_s.idle_cnt = s.idle_cnt + 4'h1;
        end
      end
    end
    if (i_tx_shift_load) begin
      next_s.empty = 1'b1;
    end
    if (s.empty && !i_tx_shifting && !i_tx_data_write) begin
      next_s.idle = 1'b1;
    end
    if (i_tx_data_write) begin
      next_s.empty = 1'b0;
      next_s.idle = 1'b0;
    end
    if (soft_clr) begin
      next_s.empty = 1'b1;
      next_s.idle = 1'b1;
      next_s.pe = 1'b0;
      next_s.framing_error_flag = 1'b0;
      next_s.overrun_error_flag = 1'b0;
      next_s.full = 1'b0;
      next_s.idle_cnt = 4'h0;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s.bus <= ADDR_PH;
      s.wr <= 1'b0;
      s.addr <= 4'h0;
      s.pe <= 1'b0;
      s.framing_error_flag <= 1'b0;
      s.overrun_error_flag <= 1'b0;
      s.full <= 1'b0;
      s.empty <= 1'b1;
      s.idle <= 1'b1;
      s.frame <= `FRAME_RESET;
      s.ctrl <= 5'h00;
      s.mode <= `MODE_NORMAL;
      s.fifo_en <= 1'b0;
      s.idle_cnt <= 4'h0;
      o_hrdata <= 32'h0000_0000;
    end else begin
      s <= next_s;
      if (rd_en) begin
        case (i_haddr[3:0])
          `ADDR_STATUS:  o_hrdata <= {24'h000000, 1'b0, 1'b0,
                                      next_s.pe, next_s.framing_error_flag,
                                      next_s.overrun_error_flag, next_s.full,
                                      next_s.empty, next_s.idle};
          `ADDR_FRAME:   o_hrdata <= {24'h000000, next_s.frame};
          `ADDR_CONTROL: o_hrdata <= {27'h0000000, next_s.ctrl};
          `ADDR_MODE:    o_hrdata <= {29'h00000000, next_s.mode};
          default:       o_hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_rx_irq = s.ctrl[`CT_RIE_BIT] &&
                    (s.full || any_err);
  assign o_tx_irq = (s.ctrl[`CT_TIE_BIT] && s.empty) ||
                    (s.ctrl[`CT_TX_IDLE_INTERRUPT_ENABLE_BIT] && s.idle);
  assign o_flow_control_on = s.frame[`FR_FLOW_BIT];
  assign o_stop_bits = {1'b0, s.frame[`FR_EXT_BIT], 1'b0} +
                       {2'b00, s.ctrl[`CT_BASE_BIT]} + 3'h1;
  assign o_line_out = i_tx_bit ^ s.frame[`FR_INV_BIT];
  assign o_rx_bit = i_line_in ^ s.frame[`FR_INV_BIT];
  assign o_parity_on = s.frame[`FR_PEN_BIT] && normal;
  assign o_parity_odd = s.frame[`FR_ODD_BIT];
  assign o_check_first_stop_only = 1'b1;
  assign o_fifo_store_ok = s.fifo_en && !any_err;
  assign o_rx_data_valid = !any_err;
  assign o_soft_clear = soft_clr;

  always_comb begin
    case (s.frame[2:0])
      3'h0:    o_data_bits = 4'h8;
      3'h1:    o_data_bits = 4'h5;
      3'h2:    o_data_bits = 4'h6;
      3'h3:    o_data_bits = 4'h7;
      3'h4:    o_data_bits = 4'h9;
      default: o_data_bits = 4'h8;
    endcase
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_clear;
    @(posedge i_clock) disable iff (!i_rst_n)
    err_clr && !i_rx_word_valid && !i_rx_overrun |=> !s.pe && !s.framing_error_flag
      && !s.overrun_error_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
  property p_pe;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_rx_word_valid && o_parity_on && i_rx_parity_bad && !soft_clr |=> s.pe;
  endproperty
  a_pe: assert property (p_pe) else $error("pe not set");
  property p_fre;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_rx_word_valid && i_rx_stop_bad && !soft_clr |=> s.framing_error_flag;
  endproperty
  a_fre: assert property (p_fre) else $error("fre not set");
  property p_ore;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_rx_overrun && !soft_clr |=> s.overrun_error_flag;
  endproperty
  a_ore: assert property (p_ore) else $error("ore not set");
  property p_rxirq;
    @(posedge i_clock) disable iff (!i_rst_n)
    o_rx_irq == (s.ctrl[`CT_RIE_BIT] && (s.full || s.pe || s.framing_error_flag || s.overrun_error_flag));
  endproperty
  a_rxirq: assert property (p_rxirq) else $error("rx irq");
  property p_fifo_drop;
    @(posedge i_clock) disable iff (!i_rst_n)
    (s.pe || s.framing_error_flag || s.overrun_error_flag) |=> !s.fifo_en;
  endproperty
  a_fifo_drop: assert property (p_fifo_drop) else $error("fifo on");
  property p_txw;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_tx_data_write && !soft_clr |=> !s.empty && !s.idle;
  endproperty
  a_txw: assert property (p_txw) else $error("tx write");
  property p_soft;
    @(posedge i_clock) disable iff (!i_rst_n)
    soft_clr |=> s.empty && s.idle;
  endproperty
  a_soft: assert property (p_soft) else $error("soft clear");
  property p_par_mode;
    @(posedge i_clock) disable iff (!i_rst_n)
    (s.mode == `MODE_MULTI) |-> !o_parity_on;
  endproperty
  a_par_mode: assert property (p_par_mode) else $error("parity");

  // ************************************************************
  // Assertions: receive flags
  // ************************************************************
  property p_pe_hold;
    @(posedge i_clock) disable iff (!i_rst_n)
    s.pe && !err_clr && !soft_clr |=> s.pe;
  endproperty
  a_pe_hold: assert property (p_pe_hold) else $error("pe lost");
  property p_fre_hold;
    @(posedge i_clock) disable iff (!i_rst_n)
    s.framing_error_flag && !err_clr && !soft_clr |=> s.framing_error_flag;
  endproperty
  a_fre_hold: assert property (p_fre_hold) else $error("fre lost");
  property p_ore_hold;
    @(posedge i_clock) disable iff (!i_rst_n)
    s.overrun_error_flag && !err_clr && !soft_clr |=> s.overrun_error_flag;
  endproperty
  a_ore_hold: assert property (p_ore_hold) else $error("ore lost");
  property p_bad_word;
    @(posedge i_clock) disable iff (!i_rst_n)
    any_err |-> !o_rx_data_valid && !o_fifo_store_ok;
  endproperty
  a_bad_word: assert property (p_bad_word) else $error("bad word");
  property p_load;
    @(posedge i_clock) disable iff (!i_rst_n)
    !s.fifo_en && i_rx_word_valid && !soft_clr |=> s.full;
  endproperty
  a_load: assert property (p_load) else $error("full not set");
  property p_read;
    @(posedge i_clock) disable iff (!i_rst_n)
    !s.fifo_en && i_rx_data_read && !i_rx_word_valid && !soft_clr
      |=> !s.full;
  endproperty
  a_read: assert property (p_read) else $error("full kept");
  property p_count;
    @(posedge i_clock) disable iff (!i_rst_n)
    s.fifo_en && i_fifo_count_reached && !soft_clr |=> s.full;
  endproperty
  a_count: assert property (p_count) else $error("count");
  property p_drain;
    @(posedge i_clock) disable iff (!i_rst_n)
    s.fifo_en && i_fifo_empty && !i_fifo_count_reached |=> !s.full;
  endproperty
  a_drain: assert property (p_drain) else $error("drain");
  property p_idle_cap;
    @(posedge i_clock) disable iff (!i_rst_n)
    s.idle_cnt <= `IDLE_BAUD_COUNT;
  endproperty
  a_idle_cap: assert property (p_idle_cap) else $error("cap");
  property p_idle_set;
    @(posedge i_clock) disable iff (!i_rst_n)
    s.fifo_en && s.ctrl[`CT_FIDLE_BIT] && !i_fifo_empty &&
      !i_fifo_count_reached && i_rx_line_idle && !i_rx_data_read &&
      i_baud_tick && (s.idle_cnt == `IDLE_BAUD_COUNT) && !soft_clr
      |=> s.full;
  endproperty
  a_idle_set: assert property (p_idle_set) else $error("idle");
  property p_restart;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_rx_data_read |=> (s.idle_cnt == 4'h0);
  endproperty
  a_restart: assert property (p_restart) else $error("restart");

  // ************************************************************
  // Assertions: transmit flags and frame
  // ************************************************************
  property p_shift;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_tx_shift_load && !i_tx_data_write |=> s.empty;
  endproperty
  a_shift: assert property (p_shift) else $error("shift");
  property p_tie;
    @(posedge i_clock) disable iff (!i_rst_n)
    s.ctrl[`CT_TIE_BIT] && s.empty |-> o_tx_irq;
  endproperty
  a_tie: assert property (p_tie) else $error("tie");
  property p_drained;
    @(posedge i_clock) disable iff (!i_rst_n)
    s.empty && !i_tx_shifting && !i_tx_data_write |=> s.idle;
  endproperty
  a_drained: assert property (p_drained) else $error("drained");
  property p_tx_idle_interrupt_enable;
    @(posedge i_clock) disable iff (!i_rst_n)
    s.ctrl[`CT_TX_IDLE_INTERRUPT_ENABLE_BIT] && s.idle |-> o_tx_irq;
  endproperty
  a_tx_idle_interrupt_enable: assert property (p_tx_idle_interrupt_enable) else $error("tx_idle_interrupt_enable");
  property p_stop_max;
    @(posedge i_clock) disable iff (!i_rst_n)
    s.frame[`FR_EXT_BIT] && s.ctrl[`CT_BASE_BIT] |-> (o_stop_bits == 3'h4);
  endproperty
  a_stop_max: assert property (p_stop_max) else $error("stop");
  property p_nine;
    @(posedge i_clock) disable iff (!i_rst_n)
    (s.frame[2:0] == 3'h4) |-> (o_data_bits == 4'h9);
  endproperty
  a_nine: assert property (p_nine) else $error("nine");
endmodule : uart_status_and_frame_config

//--- dv/remote_peer.sv
`timescale 1ns/1ps
module remote_peer (
  // Clock
  input  wire logic i_clock,
  // Frame drive
  input  wire logic i_send,
  input  wire logic i_bit,
  input  wire logic i_inverted,
  // Line
  output logic      o_line
);
  // ****************************
  // Line driver, mark when idle
  // ****************************
  always @(posedge i_clock) begin
    o_line <= (i_send ? i_bit : 1'b1) ^ i_inverted;
  end
endmodule : remote_peer

//--- dv/uart_status_and_frame_config_tb.sv
`timescale 1ns/1ps
`include "uart_status_defines.svh"
module uart_status_and_frame_config_tb;
  import uart_status_pkg::*;
  logic i_clock, i_rst_n, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize, o_stop_bits;
  logic [3:0] o_data_bits;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic i_rx_word_valid, i_rx_parity_bad, i_rx_stop_bad, i_rx_overrun;
  logic i_rx_data_read, i_fifo_enable_req, i_fifo_count_reached;
  logic i_fifo_empty, i_rx_line_idle, i_baud_tick, i_tx_data_write;
  logic i_tx_shift_load, i_tx_shifting, i_line_in, i_tx_bit, o_line_out;
  logic o_rx_bit, o_rx_irq, o_tx_irq, o_flow_control_on, o_parity_on;
  logic o_parity_odd, o_check_first_stop_only, o_fifo_store_ok;
  logic o_rx_data_valid, o_soft_clear, send, sbit, polarity_flip;
  int n_mismatch, comparisons;
  assign i_hready = o_hreadyout;
  uart_status_and_frame_config dut (
    .i_clock, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
    .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
    .i_rx_word_valid, .i_rx_parity_bad, .i_rx_stop_bad, .i_rx_overrun,
    .i_rx_data_read, .i_fifo_enable_req, .i_fifo_count_reached,
    .i_fifo_empty, .i_rx_line_idle, .i_baud_tick, .i_tx_data_write,
    .i_tx_shift_load, .i_tx_shifting, .i_line_in, .i_tx_bit, .o_line_out,
    .o_rx_bit, .o_rx_irq, .o_tx_irq, .o_flow_control_on, .o_stop_bits,
    .o_data_bits, .o_parity_on, .o_parity_odd, .o_check_first_stop_only,
    .o_fifo_store_ok, .o_rx_data_valid, .o_soft_clear);
  remote_peer peer (.i_clock, .i_send(send), .i_bit(sbit),
    .i_inverted(polarity_flip), .o_line(i_line_in));
  // ****************************
  // Shared tasks
  // ****************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic hwait();
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
      if (n > 50) begin
        n_mismatch++;
        give_verdict();
      end
    end while (i_hready !== 1'b1);
  endtask : hwait
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge i_clock);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {28'h0, a};
    i_hwrite <= w;
    hwait();
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    hwait();
    rd = o_hrdata;
  endtask : bus
  task automatic st(input logic [31:0] exp);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd, exp);
  endtask : st
  task automatic give_verdict();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  // ****************************
  // Scenarios
  // ****************************
  task automatic t_rx();
    st(32'h03);
    i_rx_word_valid <= 1'b1;
    @(posedge i_clock);
    i_rx_word_valid <= 1'b0;
    @(posedge i_clock);
    #1 chk(o_rx_irq, 1'b0);
    bus(1'b1, `ADDR_FRAME, 32'h10);
    bus(1'b1, `ADDR_CONTROL, 32'h10);
    #1 chk(o_rx_irq, 1'b1);
    st(32'h07);
    i_rx_data_read <= 1'b1;
    @(posedge i_clock);
    i_rx_data_read <= 1'b0;
    st(32'h03);
    i_rx_word_valid <= 1'b1;
    i_rx_parity_bad <= 1'b1;
    i_rx_stop_bad <= 1'b1;
    i_rx_overrun <= 1'b1;
    @(posedge i_clock);
    i_rx_word_valid <= 1'b0;
    i_rx_overrun <= 1'b0;
    bus(1'b1, `ADDR_STATUS, 32'h0);
    st(32'h3F);
    chk(o_rx_data_valid, 1'b0);
    bus(1'b1, `ADDR_STATUS, 32'h80);
    st(32'h07);
    i_rx_data_read <= 1'b1;
    @(posedge i_clock);
    i_rx_data_read <= 1'b0;
    #1 chk(o_rx_irq, 1'b0);
  endtask : t_rx
  task automatic t_fifo();
    @(posedge i_clock);
    i_fifo_enable_req <= 1'b1;
    @(posedge i_clock);
    i_fifo_enable_req <= 1'b0;
    bus(1'b1, `ADDR_CONTROL, 32'h02);
    chk(o_fifo_store_ok, 1'b1);
    i_fifo_empty <= 1'b0;
    i_rx_line_idle <= 1'b1;
    for (int i = 1; i <= 9; i++) begin
      i_baud_tick <= 1'b1;
      @(posedge i_clock);
      i_baud_tick <= 1'b0;
      @(posedge i_clock);
      if (i == 8) st(32'h03);
    end
    st(32'h07);
    i_fifo_empty <= 1'b1;
    st(32'h03);
    i_fifo_empty <= 1'b0;
    i_fifo_count_reached <= 1'b1;
    i_rx_line_idle <= 1'b0;
    st(32'h07);
    i_rx_overrun <= 1'b1;
    @(posedge i_clock);
    i_rx_overrun <= 1'b0;
    @(posedge i_clock);
    i_fifo_empty <= 1'b1;
    i_fifo_count_reached <= 1'b0;
    #1 chk(o_fifo_store_ok, 1'b0);
    bus(1'b1, `ADDR_STATUS, 32'h80);
    st(32'h07);
    i_rx_data_read <= 1'b1;
    @(posedge i_clock);
    i_rx_data_read <= 1'b0;
    st(32'h03);
  endtask : t_fifo
  task automatic t_tx();
    bus(1'b1, `ADDR_CONTROL, 32'h08);
    i_tx_shifting <= 1'b1;
    i_tx_data_write <= 1'b1;
    #1 chk(o_tx_irq, 1'b1);
    @(posedge i_clock);
    i_tx_data_write <= 1'b0;
    st(32'h00);
    chk(o_tx_irq, 1'b0);
    i_tx_shift_load <= 1'b1;
    @(posedge i_clock);
    i_tx_shift_load <= 1'b0;
    st(32'h02);
    bus(1'b1, `ADDR_CONTROL, 32'h04);
    i_tx_shifting <= 1'b0;
    #1 chk(o_tx_irq, 1'b0);
    st(32'h03);
    chk(o_tx_irq, 1'b1);
    i_tx_data_write <= 1'b1;
    @(posedge i_clock);
    i_tx_data_write <= 1'b0;
    bus(1'b1, `ADDR_CONTROL, 32'h80);
    st(32'h03);
  endtask : t_tx
  task automatic t_frame();
    int len[5] = '{8, 5, 6, 7, 9};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `ADDR_FRAME, 32'(i / 2) << 6);
      bus(1'b1, `ADDR_CONTROL, 32'(i % 2));
      #1 chk(32'(o_stop_bits), 32'(i + 1));
    end
    for (int c = 0; c < 5; c++) begin
      bus(1'b1, `ADDR_FRAME, 32'(c));
      #1 chk(32'(o_data_bits), 32'(len[c]));
    end
    bus(1'b1, `ADDR_FRAME, 32'h18);
    #1 chk({o_parity_on, o_parity_odd}, 2'h3);
    bus(1'b1, `ADDR_FRAME, 32'h90);
    #1 chk({o_parity_odd, o_flow_control_on}, 2'h1);
    chk(o_check_first_stop_only, 1'b1);
    bus(1'b1, `ADDR_MODE, 32'h1);
    #1 chk(o_parity_on, 1'b0);
    bus(1'b1, `ADDR_MODE, 32'h0);
    bus(1'b1, `ADDR_FRAME, 32'h20);
    polarity_flip <= 1'b1;
    i_tx_bit <= 1'b1;
    repeat (2) @(posedge i_clock);
    #1 chk({o_line_out, o_rx_bit}, 2'h1);
    @(posedge i_clock);
    send <= 1'b1;
    sbit <= 1'b0;
    i_tx_bit <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1 chk({o_line_out, o_rx_bit}, 2'h2);
  endtask : t_frame
  // ****************************
  // Main sequence
  // ****************************
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  initial begin
    #800000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {i_rst_n, i_hsel, i_hwrite, i_htrans, i_haddr, i_hwdata} = '0;
    {i_rx_word_valid, i_rx_parity_bad, i_rx_stop_bad, i_rx_overrun} = '0;
    {i_rx_data_read, i_fifo_enable_req, i_fifo_count_reached} = '0;
    {i_rx_line_idle, i_baud_tick, i_tx_data_write, i_tx_shift_load} = '0;
    {i_tx_shifting, i_tx_bit, send, sbit, polarity_flip} = '0;
    i_fifo_empty = 1'b1;
    i_hsize = 3'h2;
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_rx();
    t_fifo();
    t_tx();
    t_frame();
    give_verdict();
  end
endmodule : uart_status_and_frame_config_tb
